// *** rtl/nvmc_pkg.sv ***
// Register map, field layout and reset values of the memory control block
package nvmc_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EPROM_CTRL = 8'h2b;
  localparam logic [7:0] IDX_EE_MAP = 8'h2d;
  localparam logic [7:0] IDX_BLOCK_PROT = 8'h35;
  localparam logic [7:0] IDX_OPTION = 8'h39;
  localparam logic [7:0] IDX_EE_CTRL = 8'h3b;
  localparam logic [7:0] IDX_MODE = 8'h3c;
  localparam logic [7:0] IDX_SYS_CFG = 8'h3f;

  // ==========================================================
  // EPROM programming control fields
  localparam int EP_MBE = 7;
  localparam int EP_LAT = 5;
  localparam int EP_XCOL = 4;
  localparam int EP_XROW = 3;
  localparam int EP_PGM = 0;
  localparam logic [7:0] EP_RESET = 8'h00;

  // ==========================================================
  // System configuration fields
  localparam int CFG_HIMAP = 3;
  localparam int CFG_PMEN = 1;
  localparam int CFG_EEEN = 0;

  // ==========================================================
  // EEPROM programming control fields
  localparam int EE_ODD = 7;
  localparam int EE_EVEN = 6;
  localparam int EE_BYTE = 4;
  localparam int EE_ROW = 3;
  localparam int EE_ERASE = 2;
  localparam int EE_LAT = 1;
  localparam int EE_PGM = 0;
  localparam logic [7:0] EE_CTRL_RESET = 8'h00;

  // ==========================================================
  // Other fields and reset values
  localparam int MAP_LO = 4;
  localparam int OPT_PUMP_CLOCK_SELECT = 3;
  localparam int MODE_BOOT = 7;
  localparam int MODE_SPEC = 6;
  localparam int MODE_EXP = 5;
  localparam logic [3:0] EE_PAGE_RESET = 4'h0;
  localparam logic [4:0] PROT_RESET = 5'h1f;
  localparam logic [6:0] PROT_WINDOW = 7'h40;

  // ==========================================================
  // Address windows
  localparam logic [15:0] PM_HI_BASE = 16'ha000;
  localparam logic [15:0] PM_LO_BASE = 16'h2000;
  localparam logic [15:0] PM_LO_TOP = 16'h7fff;
  localparam logic [11:0] EE_OFS_BASE = 12'hd80;
  localparam logic [15:0] BOOT_BASE = 16'hbe00;
  localparam logic [15:0] BOOT_TOP = 16'hbfff;
  localparam logic [11:0] PROT_B1 = 12'hda0;
  localparam logic [11:0] PROT_B2 = 12'hde0;
  localparam logic [11:0] PROT_B3 = 12'he60;
  localparam logic [11:0] PROT_B4 = 12'hf80;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_LOADED} nvmc_seq_t;

endpackage

// *** rtl/nvmc_top.sv ***
// Non-volatile memory mapping and EPROM/EEPROM programming control
// ==========================================================
`timescale 1ns/10ps
`default_nettype none

module nvmc_top
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Mode straps, caught during reset
  input wire logic mode_special_pin,
  input wire logic mode_expanded_pin,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  // Memory selects
  output logic prog_mem_sel,
  output logic eeprom_sel,
  output logic boot_rom_sel,
  output logic prog_mem_read_block,
  output logic eeprom_read_block,
  // EPROM array control
  output logic [14:0] eprom_array_addr,
  output logic [7:0] eprom_array_data,
  output logic eprom_pair_program,
  output logic eprom_user_array_off,
  output logic program_supply_pin,
  // EEPROM array control
  input wire logic rc_osc_tick,
  output logic [11:0] eeprom_target_ofs,
  output logic eeprom_pump_on,
  output logic eeprom_pump_clk_en,
  output logic pump_clock_select
);

  // ==========================================================
  // Helpers
  function automatic logic [2:0] prot_block(input logic [11:0] ofs);
    if (ofs < nvmc_pkg::PROT_B1)
      prot_block = 3'h0;
    else if (ofs < nvmc_pkg::PROT_B2)
      prot_block = 3'h1;
    else if (ofs < nvmc_pkg::PROT_B3)
      prot_block = 3'h2;
    else if (ofs < nvmc_pkg::PROT_B4)
      prot_block = 3'h3;
    else
      prot_block = 3'h4;
  endfunction

  function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
    reg_hit = (a == {22'h0, idx, 2'b00});
  endfunction

  // ==========================================================
  // State
  logic spec_q;
  logic exp_q;
  logic boot_en_q;
  logic [7:0] ep_ctrl_q;
  logic cfg_himap_q;
  logic cfg_pmen_q;
  logic cfg_eeen_q;
  logic cfg_used_q;
  logic [3:0] ee_page_q;
  logic map_used_q;
  logic [7:0] ee_ctrl_q;
  logic [4:0] prot_q;
  logic [6:0] prot_cnt_q;
  logic pump_clock_select_q;
  logic [15:0] ep_addr_q;
  logic [7:0] ep_data_q;
  logic [11:0] ee_ofs_q;
  logic ee_hv_q;
  nvmc_pkg::nvmc_seq_t seq_q;
  logic [31:0] prdata_q;

  // ==========================================================
  // Bus decode
  logic wr_en;
  logic [7:0] wd;
  logic hit_ep;
  logic hit_map;
  logic hit_prot;
  logic hit_opt;
  logic hit_ee;
  logic hit_mode;
  logic hit_cfg;
  logic hit_any;
  logic test_mode;
  logic ep_lat;
  logic ep_pgm;

  assign wd = pwdata[7:0];
  assign hit_ep = reg_hit(paddr, nvmc_pkg::IDX_EPROM_CTRL);
  assign hit_map = reg_hit(paddr, nvmc_pkg::IDX_EE_MAP);
  assign hit_prot = reg_hit(paddr, nvmc_pkg::IDX_BLOCK_PROT);
  assign hit_opt = reg_hit(paddr, nvmc_pkg::IDX_OPTION);
  assign hit_ee = reg_hit(paddr, nvmc_pkg::IDX_EE_CTRL);
  assign hit_mode = reg_hit(paddr, nvmc_pkg::IDX_MODE);
  assign hit_cfg = reg_hit(paddr, nvmc_pkg::IDX_SYS_CFG);
  assign hit_any = hit_ep | hit_map | hit_prot | hit_opt | hit_ee
                   | hit_mode | hit_cfg;
  // One wait-free access phase; read data was taken in setup
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit_any;
  assign wr_en = psel & penable & pwrite & hit_any;
  assign prdata = prdata_q;
  assign test_mode = spec_q & exp_q;
  assign ep_lat = ep_ctrl_q[nvmc_pkg::EP_LAT];
  assign ep_pgm = ep_ctrl_q[nvmc_pkg::EP_PGM];

  // ==========================================================
  // Mode straps and bootloader enable
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      spec_q <= mode_special_pin;
      exp_q <= mode_expanded_pin;
      boot_en_q <= mode_special_pin;
    end
    else if (wr_en && hit_mode && spec_q)
    begin
      boot_en_q <= wd[nvmc_pkg::MODE_BOOT];
    end
  end

  // ==========================================================
  // System configuration, write-once in normal modes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_himap_q <= 1'b1;
      cfg_pmen_q <= ~(mode_special_pin & mode_expanded_pin);
      cfg_eeen_q <= 1'b1;
      cfg_used_q <= 1'b0;
    end
    else if (wr_en && hit_cfg && (spec_q || !cfg_used_q))
    begin
      cfg_himap_q <= wd[nvmc_pkg::CFG_HIMAP];
      cfg_pmen_q <= wd[nvmc_pkg::CFG_PMEN];
      cfg_eeen_q <= wd[nvmc_pkg::CFG_EEEN];
      cfg_used_q <= ~spec_q;
    end
  end

  // ==========================================================
  // EEPROM map position, write-once in normal modes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ee_page_q <= nvmc_pkg::EE_PAGE_RESET;
      map_used_q <= 1'b0;
    end
    else if (wr_en && hit_map && (spec_q || !map_used_q))
    begin
      ee_page_q <= wd[nvmc_pkg::MAP_LO +: 4];
      map_used_q <= ~spec_q;
    end
  end

  // ==========================================================
  // Block protect and clock select
  // Clearing protection is a hazard, so outside special mode it is only open for the first 64 cycles after reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prot_q <= nvmc_pkg::PROT_RESET;
      prot_cnt_q <= 7'h00;
      pump_clock_select_q <= 1'b0;
    end
    else
    begin
      if (prot_cnt_q != nvmc_pkg::PROT_WINDOW)
        prot_cnt_q <= prot_cnt_q + 7'h01;
      if (wr_en && hit_prot)
      begin
        if (spec_q || prot_cnt_q != nvmc_pkg::PROT_WINDOW)
          prot_q <= wd[4:0];
        else
          prot_q <= prot_q | wd[4:0];
      end
      if (wr_en && hit_opt)
        pump_clock_select_q <= wd[nvmc_pkg::OPT_PUMP_CLOCK_SELECT];
    end
  end

  // ==========================================================
  // EPROM programming control
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ep_ctrl_q <= nvmc_pkg::EP_RESET;
    end
    else if (wr_en && hit_ep)
    begin
      if (!ep_pgm)
        ep_ctrl_q[nvmc_pkg::EP_LAT] <= wd[nvmc_pkg::EP_LAT];
      if (ep_lat)
        ep_ctrl_q[nvmc_pkg::EP_PGM] <= wd[nvmc_pkg::EP_PGM];
      if (test_mode)
      begin
        ep_ctrl_q[nvmc_pkg::EP_MBE] <= wd[nvmc_pkg::EP_MBE];
        ep_ctrl_q[nvmc_pkg::EP_XCOL] <= wd[nvmc_pkg::EP_XCOL];
        ep_ctrl_q[nvmc_pkg::EP_XROW] <= wd[nvmc_pkg::EP_XROW];
      end
    end
  end

  // ==========================================================
  // Memory decode
  logic pm_hit;
  logic ee_hit;
  logic [15:0] pm_ofs;
  logic [15:0] ea;

  always_comb
  begin
    if (cfg_himap_q || !exp_q)
    begin
      pm_hit = mem_addr >= nvmc_pkg::PM_HI_BASE;
      pm_ofs = mem_addr - nvmc_pkg::PM_HI_BASE;
    end
    else
    begin
      pm_hit = mem_addr >= nvmc_pkg::PM_LO_BASE
               && mem_addr <= nvmc_pkg::PM_LO_TOP;
      pm_ofs = mem_addr - nvmc_pkg::PM_LO_BASE;
    end
    pm_hit = pm_hit & cfg_pmen_q;
  end

  assign ee_hit = cfg_eeen_q
                  && mem_addr[15:12] == ee_page_q
                  && mem_addr[11:0] >= nvmc_pkg::EE_OFS_BASE;
  assign prog_mem_sel = pm_hit;
  assign eeprom_sel = ee_hit;
  // Boot ROM hosts the serial download utility
  assign boot_rom_sel = spec_q & boot_en_q
                        && mem_addr >= nvmc_pkg::BOOT_BASE
                        && mem_addr <= nvmc_pkg::BOOT_TOP;
  assign prog_mem_read_block = pm_hit & ep_lat;
  assign eeprom_read_block = ee_hit & ee_ctrl_q[nvmc_pkg::EE_LAT];

  // ==========================================================
  // EPROM address and data latch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ep_addr_q <= 16'h0000;
      ep_data_q <= 8'h00;
    end
    else if (mem_wr && pm_hit && ep_lat && !ep_pgm)
    begin
      ep_addr_q <= pm_ofs;
      ep_data_q <= mem_wdata;
    end
  end

  always_comb
  begin
    ea = ep_addr_q;
    if (ep_ctrl_q[nvmc_pkg::EP_MBE])
      ea[5] = 1'b0;
    if (ep_ctrl_q[nvmc_pkg::EP_XCOL])
      ea = {4'h0, ep_addr_q[11:5], 5'h00};
    else if (ep_ctrl_q[nvmc_pkg::EP_XROW])
      ea = {10'h000, ep_addr_q[5:0]};
  end

  assign eprom_array_addr = ea[14:0];
  assign eprom_array_data = ep_data_q;
  assign eprom_pair_program = ep_ctrl_q[nvmc_pkg::EP_MBE];
  assign eprom_user_array_off = ep_ctrl_q[nvmc_pkg::EP_XCOL]
                                | ep_ctrl_q[nvmc_pkg::EP_XROW];
  // Supply only switched on; enable bit is software's duty
  assign program_supply_pin = ep_pgm & ep_lat;

  // ==========================================================
  // EEPROM control and enforced sequence
  logic both_new;
  logic ee_tgt_wr;

  assign both_new = wd[nvmc_pkg::EE_LAT] & wd[nvmc_pkg::EE_PGM]
                    & ~ee_ctrl_q[nvmc_pkg::EE_LAT];
  assign ee_tgt_wr = (mem_wr && ee_hit) || (wr_en && hit_cfg);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ee_ctrl_q <= nvmc_pkg::EE_CTRL_RESET;
    end
    else if (wr_en && hit_ee)
    begin
      ee_ctrl_q[nvmc_pkg::EE_BYTE] <= wd[nvmc_pkg::EE_BYTE];
      ee_ctrl_q[nvmc_pkg::EE_ROW] <= wd[nvmc_pkg::EE_ROW];
      ee_ctrl_q[nvmc_pkg::EE_ERASE] <= wd[nvmc_pkg::EE_ERASE];
      if (test_mode)
      begin
        ee_ctrl_q[nvmc_pkg::EE_ODD] <= wd[nvmc_pkg::EE_ODD];
        ee_ctrl_q[nvmc_pkg::EE_EVEN] <= wd[nvmc_pkg::EE_EVEN];
      end
      if (both_new)
      begin
        ee_ctrl_q[nvmc_pkg::EE_LAT] <= 1'b0;
        ee_ctrl_q[nvmc_pkg::EE_PGM] <= 1'b0;
      end
      else
      begin
        ee_ctrl_q[nvmc_pkg::EE_LAT] <= wd[nvmc_pkg::EE_LAT];
        ee_ctrl_q[nvmc_pkg::EE_PGM] <= wd[nvmc_pkg::EE_PGM];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      seq_q <= nvmc_pkg::SEQ_IDLE;
      ee_hv_q <= 1'b0;
      ee_ofs_q <= 12'h000;
    end
    else if (wr_en && hit_ee)
    begin
      ee_hv_q <= 1'b0;
      seq_q <= nvmc_pkg::SEQ_IDLE;
      if (wd[nvmc_pkg::EE_LAT] && !wd[nvmc_pkg::EE_PGM])
        seq_q <= nvmc_pkg::SEQ_ARMED;
      else if (wd[nvmc_pkg::EE_LAT] && wd[nvmc_pkg::EE_PGM] && !both_new
               && seq_q == nvmc_pkg::SEQ_LOADED)
      begin
        ee_hv_q <= ~prot_q[prot_block(ee_ofs_q)];
        seq_q <= nvmc_pkg::SEQ_LOADED;
      end
    end
    else if (ee_tgt_wr && !ee_hv_q && seq_q != nvmc_pkg::SEQ_IDLE)
    begin
      seq_q <= nvmc_pkg::SEQ_LOADED;
      ee_ofs_q <= (mem_wr && ee_hit) ? mem_addr[11:0] : nvmc_pkg::PROT_B4;
    end
  end

  assign eeprom_pump_on = ee_hv_q;
  assign eeprom_target_ofs = ee_ofs_q;
  assign pump_clock_select = pump_clock_select_q;
  assign eeprom_pump_clk_en = pump_clock_select_q ? rc_osc_tick : 1'b1;

  // ==========================================================
  // Read data, taken in the setup phase
  logic [7:0] rd;

  always_comb
  begin
    rd = 8'h00;
    if (hit_ep)
      rd = ep_ctrl_q;
    else if (hit_map)
      rd = {ee_page_q, 4'h0};
    else if (hit_prot)
      rd = {3'h0, prot_q};
    else if (hit_opt)
      rd = {4'h0, pump_clock_select_q, 3'h0};
    else if (hit_ee)
      rd = ee_ctrl_q;
    else if (hit_mode)
      rd = {boot_en_q, spec_q, exp_q, 5'h00};
    else if (hit_cfg)
      rd = {4'h0, cfg_himap_q, 1'b0, cfg_pmen_q, cfg_eeen_q};
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= {24'h00_0000, rd};
  end

endmodule

`default_nettype wire

// *** verif/nvmc_cpu_model.sv ***
// Behavioural processor core driving the CPU memory bus
`timescale 1ns/10ps
`default_nettype none
module nvmc_cpu_model
(
  // Clock
  input wire logic clk_sys,
  // CPU memory bus
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata
);
  // ==========
  // Idle bus
  initial
  begin
    mem_addr = 16'h0000;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_wdata = 8'h00;
  end
  // ==========
  // Read: address held until the next request
  task automatic look(input logic [15:0] a);
    @(posedge clk_sys);
    mem_addr <= a;
    mem_rd <= 1'b1;
  endtask
  // Write: one-cycle strobe; data inverted once released so that
  // stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_addr <= a;
    mem_wdata <= d;
    mem_rd <= 1'b0;
    mem_wr <= 1'b1;
    @(posedge clk_sys);
    mem_wr <= 1'b0;
    mem_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** verif/nvmc_monitor.sv ***
// Port-level checker for the memory control block
`timescale 1ns/10ps
`default_nettype none
module nvmc_monitor
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // CPU bus and selects
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic prog_mem_sel,
  input wire logic eeprom_sel,
  input wire logic boot_rom_sel,
  input wire logic prog_mem_read_block,
  // Array control
  input wire logic [7:0] eprom_array_data,
  input wire logic program_supply_pin,
  input wire logic rc_osc_tick,
  input wire logic eeprom_pump_on,
  input wire logic eeprom_pump_clk_en,
  input wire logic pump_clock_select
);
  // ==========
  // Helpers
  logic cap;
  logic wr_ep;
  logic wr_ee;
  assign cap = mem_wr && prog_mem_read_block && !program_supply_pin;
  assign wr_ep = psel && penable && pwrite
    && paddr == {22'h0, nvmc_pkg::IDX_EPROM_CTRL, 2'h0};
  assign wr_ee = psel && penable && pwrite
    && paddr == {22'h0, nvmc_pkg::IDX_EE_CTRL, 2'h0};
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  a_ready_no_wait: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  a_pm_window: assert property (prog_mem_sel |-> mem_addr >= 16'h2000
    && (mem_addr <= 16'h7fff || mem_addr >= 16'ha000))
    else $error("program memory select outside its windows");
  a_ee_offset: assert property (eeprom_sel |-> mem_addr[11:0] >= 12'hd80)
    else $error("EEPROM select below offset d80");
  a_boot_window: assert property (boot_rom_sel |-> mem_addr[15:9] == 7'h5f)
    else $error("boot ROM select outside be00-bfff");
  a_pump_clock: assert property (eeprom_pump_clk_en
    == (pump_clock_select ? rc_osc_tick : 1'b1))
    else $error("pump clock enable wrong source");
  a_latch_capture: assert property (cap |=> eprom_array_data == $past(mem_wdata))
    else $error("EPROM data not captured");
  a_latch_hold: assert property (!cap |=> $stable(eprom_array_data))
    else $error("EPROM data changed without capture");
  a_supply_blocks: assert property (program_supply_pin && prog_mem_sel
    |-> prog_mem_read_block)
    else $error("supply on without latch");
  a_supply_cause: assert property ($rose(program_supply_pin)
    |-> $past(wr_ep && pwdata[0]))
    else $error("supply rose without voltage write");
  a_pump_cause: assert property ($rose(eeprom_pump_on)
    |-> $past(wr_ee && pwdata[1:0] == 2'b11))
    else $error("pump rose without final sequence write");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the memory control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, s) \
  begin \
    checks_done++; \
    if ((s) !== (x)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s exp %h got %h", n, x, s); \
    end \
  end
module tb_top;
  localparam logic [7:0] EPC = nvmc_pkg::IDX_EPROM_CTRL;
  localparam logic [7:0] MAPR = nvmc_pkg::IDX_EE_MAP;
  localparam logic [7:0] PROT = nvmc_pkg::IDX_BLOCK_PROT;
  localparam logic [7:0] OPT = nvmc_pkg::IDX_OPTION;
  localparam logic [7:0] EEC = nvmc_pkg::IDX_EE_CTRL;
  localparam logic [7:0] MODR = nvmc_pkg::IDX_MODE;
  localparam logic [7:0] CFG = nvmc_pkg::IDX_SYS_CFG;
  logic clk_sys = 1'b0;
  logic rst, spec, expd, psel, penable, pwrite, pready, pslverr, rc_tick;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] mem_addr;
  logic mem_rd, mem_wr, pm_sel, ee_sel, boot_sel, pm_blk, ee_blk;
  logic pair, uoff, supply, pump_on, pump_en, pump_pump_clock_select;
  logic [7:0] mem_wdata, ep_data;
  logic [14:0] ep_addr;
  logic [11:0] ee_ofs;
  int failures = 0;
  int checks_done = 0;
  // ==========
  // Clock, design and core model
  always #4 clk_sys = ~clk_sys;
  nvmc_top i_dut (.clk_sys(clk_sys), .rst(rst), .mode_special_pin(spec),
    .mode_expanded_pin(expd), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .prog_mem_sel(pm_sel), .eeprom_sel(ee_sel), .boot_rom_sel(boot_sel),
    .prog_mem_read_block(pm_blk), .eeprom_read_block(ee_blk),
    .eprom_array_addr(ep_addr), .eprom_array_data(ep_data),
    .eprom_pair_program(pair), .eprom_user_array_off(uoff),
    .program_supply_pin(supply), .rc_osc_tick(rc_tick),
    .eeprom_target_ofs(ee_ofs), .eeprom_pump_on(pump_on),
    .eeprom_pump_clk_en(pump_en), .pump_clock_select(pump_pump_clock_select));
  nvmc_cpu_model i_cpu (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
  // ==========
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] i,
    input logic [7:0] d, output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, i, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] i, input logic [7:0] m,
    input logic [7:0] x);
    logic [7:0] q;
    logic e;
    apb(1'b0, i, 8'h00, q, e);
    `CHK("register", x, q & m)
  endtask
  task automatic at(input logic [15:0] a);
    i_cpu.look(a);
    @(negedge clk_sys);
  endtask
  task automatic reset_to(input logic s, input logic x);
    @(posedge clk_sys);
    rst <= 1'b1;
    spec <= s;
    expd <= x;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    logic [7:0] q;
    logic e;
    rchk(EPC, 8'hff, nvmc_pkg::EP_RESET);
    rchk(CFG, 8'h0b, 8'h0b);
    at(16'ha000); `CHK("pm_hi", 1'b1, pm_sel)
    at(16'h0d80); `CHK("ee_lo", 1'b1, ee_sel)
    at(16'h0d7f); `CHK("ee_gap", 1'b0, ee_sel)
    at(16'hbe00); `CHK("boot_normal", 1'b0, boot_sel)
    apb(1'b0, 8'h00, 8'h00, q, e); `CHK("slverr", 1'b1, e)
  endtask
  task automatic t_eprom;
    wr(EPC, 8'h01); rchk(EPC, 8'hff, 8'h00);
    wr(EPC, 8'h98); rchk(EPC, 8'hff, 8'h00);
    wr(EPC, 8'h20);
    i_cpu.wr(16'ha123, 8'h5a);
    at(16'ha123); `CHK("ep_data", 8'h5a, ep_data)
    `CHK("ep_addr", 15'h0123, ep_addr)
    `CHK("pm_block", 1'b1, pm_blk)
    wr(EPC, 8'h21); rchk(EPC, 8'hff, 8'h21);
    `CHK("supply_on", 1'b1, supply)
    wr(EPC, 8'h01); rchk(EPC, 8'hff, 8'h21);
    i_cpu.wr(16'ha124, 8'h33);
    at(16'ha124); `CHK("ep_hold", 8'h5a, ep_data)
    wr(EPC, 8'h00); wr(EPC, 8'h00); rchk(EPC, 8'hff, 8'h00);
    `CHK("supply_off", 1'b0, supply)
    `CHK("pm_read", 1'b0, pm_blk)
  endtask
  task automatic t_once;
    wr(MAPR, 8'h50); wr(MAPR, 8'h30); rchk(MAPR, 8'hf0, 8'h50);
    at(16'h5d80); `CHK("ee_page", 1'b1, ee_sel)
    wr(CFG, 8'h0a); wr(CFG, 8'h0b); rchk(CFG, 8'h0b, 8'h0a);
    at(16'h5d80); `CHK("ee_off", 1'b0, ee_sel)
  endtask
  task automatic t_ee;
    rchk(CFG, 8'h0b, 8'h09);
    at(16'ha000); `CHK("pm_test", 1'b0, pm_sel)
    `CHK("clk_e", 1'b1, pump_en)
    wr(PROT, 8'h00);
    wr(EEC, 8'h03); rchk(EEC, 8'h03, 8'h00);
    wr(EEC, 8'h02); i_cpu.wr(16'h0f90, 8'h11); wr(EEC, 8'h03);
    repeat (2) @(negedge clk_sys); `CHK("pump", 1'b1, pump_on)
    `CHK("ofs", 12'hf90, ee_ofs)
    `CHK("ee_blk", 1'b1, ee_blk)
    wr(EEC, 8'h00); rchk(EEC, 8'hff, 8'h00);
    `CHK("pump_off", 1'b0, pump_on)
    wr(PROT, 8'h1f); wr(EEC, 8'h02); i_cpu.wr(16'h0f90, 8'h11);
    wr(EEC, 8'h03); repeat (2) @(negedge clk_sys);
    `CHK("pump_prot", 1'b0, pump_on)
    wr(OPT, 8'h08); @(posedge clk_sys); rc_tick <= 1'b1;
    @(negedge clk_sys); `CHK("clk_rc1", 1'b1, pump_en)
    @(posedge clk_sys); rc_tick <= 1'b0;
    @(negedge clk_sys); `CHK("clk_rc0", 1'b0, pump_en)
  endtask
  task automatic t_test;
    at(16'hbe00); `CHK("boot_on", 1'b1, boot_sel)
    wr(MODR, 8'h00); at(16'hbe00); `CHK("boot_off", 1'b0, boot_sel)
    wr(CFG, 8'h0a); wr(CFG, 8'h03); rchk(CFG, 8'h0b, 8'h03);
    at(16'h2000); `CHK("pm_low", 1'b1, pm_sel)
    wr(CFG, 8'h0b); wr(EPC, 8'ha0);
    i_cpu.wr(16'ha020, 8'h77); at(16'ha020);
    `CHK("pair", 1'b1, pair)
    `CHK("bit5", 1'b0, ep_addr[5])
    wr(EPC, 8'h00); wr(EPC, 8'h10); @(negedge clk_sys);
    `CHK("xcol", 1'b1, uoff)
    wr(EPC, 8'h08); @(negedge clk_sys); `CHK("xrow", 1'b1, uoff)
    wr(EPC, 8'h00); @(negedge clk_sys); `CHK("user", 1'b0, uoff)
    wr(MAPR, 8'h20); wr(MAPR, 8'h30); rchk(MAPR, 8'hf0, 8'h30);
  endtask
  task automatic final_report;
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    {spec, expd, psel, penable, pwrite, rc_tick} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    reset_to(1'b0, 1'b0);
    t_reset();
    t_eprom();
    t_once();
    reset_to(1'b1, 1'b1);
    t_ee();
    t_test();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report();
  end
endmodule
bind nvmc_top nvmc_monitor i_mon (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .mem_addr(mem_addr),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .prog_mem_sel(prog_mem_sel),
  .eeprom_sel(eeprom_sel), .boot_rom_sel(boot_rom_sel),
  .prog_mem_read_block(prog_mem_read_block),
  .eprom_array_data(eprom_array_data),
  .program_supply_pin(program_supply_pin), .rc_osc_tick(rc_osc_tick),
  .eeprom_pump_on(eeprom_pump_on), .eeprom_pump_clk_en(eeprom_pump_clk_en),
  .pump_clock_select(pump_clock_select));
`default_nettype wire
